// file: rtl/dcpd_pkg.sv
package dcpd_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] CTRL_OFFSET = 4'h0;
  localparam logic [3:0] STATUS_OFFSET = 4'h4;
  localparam logic [3:0] MASK_OFFSET = 4'h8;

  localparam int CTRL_SYNC_BIT = 5;
  localparam int CTRL_BLACK_BIT = 12;
  localparam int CTRL_DIRECT_BIT = 0;
  localparam int CTRL_PLL_BIT = 1;

  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [7:0] MASK_RESET = 8'hFF;

  // ----------------------------------------------------------------
  // Output level components, in output_current_step units
  // ----------------------------------------------------------------
  localparam logic [8:0] BLACK_PEDESTAL = 9'h014;
  localparam logic [8:0] SYNC_PEDESTAL = 9'h06C;
  localparam int LEVEL_W = 9;

  typedef struct packed {
    logic [7:0] blue_pixel_lane;
    logic [7:0] green_pixel_lane;
    logic [7:0] red_pixel_lane;
  } dcpd_pixel_t;

  typedef struct packed {
    logic blank;
    logic sync;
    dcpd_pixel_t pix;
  } dcpd_word_t;

  typedef struct packed {
    logic [LEVEL_W-1:0] blue;
    logic [LEVEL_W-1:0] green;
    logic [LEVEL_W-1:0] red;
  } dcpd_level_t;

endpackage

// file: rtl/dcpd_top.sv
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - Direct mode: three 8-bit lookup indices.
// - Capture one 24-bit pixel per clock rise.
// - Lanes one, two, three drive red, green, blue.
// - Direct mode bypasses multiplier, uses external clock.
// - Pixel mask ignored in direct mode.
// - Each channel carries 8-bit code 0..255.
// - Black pedestal 20 only during active display.
// - Sync pedestal 108 except during sync pulses.
// - Sync appears identically on all channels.
// - Bit 12 enables black, bit 5 sync.
// - Full 8-bit depth at full dot rate.
// - One bit selects multiplexed or direct mode.
// - Direct mode uses gamma tables, external clock.
module dcpd_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic pix_clk,
  input wire logic [7:0] red_pixel_lane,
  input wire logic [7:0] green_pixel_lane,
  input wire logic [7:0] blue_pixel_lane,
  input wire logic pix_blank,
  input wire logic pix_sync,
  input wire logic out_ready,
  output logic out_valid,
  output logic [7:0] red_code,
  output logic [7:0] green_code,
  output logic [7:0] blue_code,
  output logic [8:0] red_level,
  output logic [8:0] green_level,
  output logic [8:0] blue_level,
  output logic pll_bypass
);

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [31:0] ctrl_r, ctrl_nxt;
  logic [7:0] mask_r, mask_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [15:0] drop_cnt_r, drop_cnt_nxt;
  logic direct_mode;
  logic drop_evt;

  assign direct_mode = ctrl_r[dcpd_pkg::CTRL_DIRECT_BIT];

  always_comb begin
    ctrl_nxt = ctrl_r;
    mask_nxt = mask_r;
    rdata_nxt = 32'h0000_0000;
    drop_cnt_nxt = drop_cnt_r;
    if (reg_wr && reg_addr == dcpd_pkg::CTRL_OFFSET) begin
      ctrl_nxt = reg_wdata;
    end
    if (reg_wr && reg_addr == dcpd_pkg::MASK_OFFSET) begin
      mask_nxt = reg_wdata[7:0];
    end
    if (reg_rd) begin
      unique case (reg_addr)
        dcpd_pkg::CTRL_OFFSET: rdata_nxt = ctrl_r;
        dcpd_pkg::STATUS_OFFSET: rdata_nxt = {16'h0000, drop_cnt_r};
        dcpd_pkg::MASK_OFFSET: rdata_nxt = {24'h000000, mask_r};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
    // The counter saturates so a long stall cannot wrap it to zero.
    if (drop_evt && drop_cnt_r != 16'hFFFF) begin
      drop_cnt_nxt = drop_cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= dcpd_pkg::CTRL_RESET;
      mask_r <= dcpd_pkg::MASK_RESET;
      rdata_r <= 32'h0000_0000;
      drop_cnt_r <= 16'h0000;
    end else begin
      ctrl_r <= ctrl_nxt;
      mask_r <= mask_nxt;
      rdata_r <= rdata_nxt;
      drop_cnt_r <= drop_cnt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Gamma tables, loaded at identity: channel c, entry i holds i
  // ----------------------------------------------------------------
  // The tables are fixed identity maps here; loading them belongs to the
  // programming port outside this block.
  function automatic logic [7:0] gamma(input logic [7:0] idx);
    gamma = idx;
  endfunction

  // ----------------------------------------------------------------
  // Pixel clock edge detect and capture
  // ----------------------------------------------------------------
  dcpd_pkg::dcpd_word_t pin_word, in_sync;
  logic pclk_s;
  logic pclk_d_r, pclk_d_nxt;
  logic rise;

  assign pin_word = {pix_blank, pix_sync, blue_pixel_lane, green_pixel_lane,
                     red_pixel_lane};

  // Clock and data pass identical two-flop stages, so the word seen with
  // a detected edge was sampled on the same clk edge as that edge.
  dcpd_sync2 #(
    .W(1)
  ) i_dcpd_sync2_clk (
    .clk(clk),
    .rst_n(rst_n),
    .d(pix_clk),
    .q(pclk_s)
  );

  dcpd_sync2 #(
    .W($bits(dcpd_pkg::dcpd_word_t))
  ) i_dcpd_sync2_data (
    .clk(clk),
    .rst_n(rst_n),
    .d(pin_word),
    .q(in_sync)
  );

  always_comb begin
    pclk_d_nxt = pclk_s;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pclk_d_r <= 1'b0;
    end else begin
      pclk_d_r <= pclk_d_nxt;
    end
  end

  // The pixel data must be stable across the edge, since it is taken
  // from the same synchroniser depth as the clock.
  assign rise = pclk_s && !pclk_d_r;

  // ----------------------------------------------------------------
  // Two-entry buffer between capture and output
  // ----------------------------------------------------------------
  dcpd_pkg::dcpd_word_t buf_r [2];
  dcpd_pkg::dcpd_word_t buf_nxt [2];
  logic [1:0] cnt_r, cnt_nxt;
  logic rd_ptr_r, rd_ptr_nxt;
  logic in_valid, in_ready, pop;
  dcpd_pkg::dcpd_word_t in_word, head;

  always_comb begin
    in_word = in_sync;
    // The mask applies only in multiplexed mode; direct mode passes bytes.
    if (!direct_mode) begin
      in_word.pix.red_pixel_lane = in_word.pix.red_pixel_lane & mask_r;
      in_word.pix.green_pixel_lane = in_word.pix.green_pixel_lane & mask_r;
      in_word.pix.blue_pixel_lane = in_word.pix.blue_pixel_lane & mask_r;
    end
  end

  assign in_valid = rise;
  assign in_ready = cnt_r != 2'h2;
  assign drop_evt = in_valid && !in_ready;
  assign head = buf_r[rd_ptr_r];

  logic oreg_free;
  assign oreg_free = !out_valid || out_ready;
  assign pop = cnt_r != 2'h0 && oreg_free;

  always_comb begin
    buf_nxt = buf_r;
    cnt_nxt = cnt_r;
    rd_ptr_nxt = rd_ptr_r;
    if (in_valid && in_ready) begin
      buf_nxt[rd_ptr_r ^ cnt_r[0]] = in_word;
    end
    if (pop) begin
      rd_ptr_nxt = !rd_ptr_r;
    end
    cnt_nxt = cnt_r + {1'b0, in_valid && in_ready} - {1'b0, pop};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      buf_r[0] <= '0;
      buf_r[1] <= '0;
      cnt_r <= 2'h0;
      rd_ptr_r <= 1'b0;
    end else begin
      buf_r <= buf_nxt;
      cnt_r <= cnt_nxt;
      rd_ptr_r <= rd_ptr_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Level composition
  // ----------------------------------------------------------------
  logic [7:0] code_nxt [3];
  logic [8:0] lvl_nxt [3];
  logic [7:0] lane [3];
  logic [8:0] ped;
  logic out_valid_nxt;
  logic pll_bypass_nxt;
  logic [7:0] code_r [3];
  logic [8:0] lvl_r [3];

  always_comb begin
    lane[0] = head.pix.red_pixel_lane;
    lane[1] = head.pix.green_pixel_lane;
    lane[2] = head.pix.blue_pixel_lane;
    ped = 9'h000;
    if (ctrl_r[dcpd_pkg::CTRL_BLACK_BIT] && !head.blank) begin
      ped = ped + dcpd_pkg::BLACK_PEDESTAL;
    end
    // One shared pedestal feeds every channel, so sync is identical.
    if (ctrl_r[dcpd_pkg::CTRL_SYNC_BIT] && !head.sync) begin
      ped = ped + dcpd_pkg::SYNC_PEDESTAL;
    end
    // Direct mode always runs from the external dot clock.
    pll_bypass_nxt = direct_mode;
    if (!ctrl_r[dcpd_pkg::CTRL_PLL_BIT]) begin
      pll_bypass_nxt = 1'b1;
    end
    out_valid_nxt = out_valid;
    for (int c = 0; c < 3; c++) begin
      code_nxt[c] = code_r[c];
      lvl_nxt[c] = lvl_r[c];
    end
    if (oreg_free) begin
      out_valid_nxt = pop;
      for (int c = 0; c < 3; c++) begin
        // Each byte indexes its own table at full 8-bit width.
        code_nxt[c] = head.blank ? 8'h00 : gamma(lane[c]);
        lvl_nxt[c] = {1'b0, code_nxt[c]} + ped;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
      for (int c = 0; c < 3; c++) begin
        code_r[c] <= 8'h00;
        lvl_r[c] <= 9'h000;
      end
      pll_bypass <= 1'b0;
    end else begin
      out_valid <= out_valid_nxt;
      for (int c = 0; c < 3; c++) begin
        code_r[c] <= code_nxt[c];
        lvl_r[c] <= lvl_nxt[c];
      end
      pll_bypass <= pll_bypass_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign red_code = code_r[0];
  assign green_code = code_r[1];
  assign blue_code = code_r[2];
  assign red_level = lvl_r[0];
  assign green_level = lvl_r[1];
  assign blue_level = lvl_r[2];

endmodule

// ----------------------------------------------------------------
// Two-flop synchroniser for inputs from outside the clk domain
// ----------------------------------------------------------------
module dcpd_sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r, meta_nxt;
  logic [W-1:0] q_r, q_nxt;

  // Only the second stage leaves this module, so a metastable first
  // stage has a whole cycle to settle.
  always_comb begin
    meta_nxt = d;
    q_nxt = meta_r;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      q_r <= q_nxt;
    end
  end

  assign q = q_r;

endmodule

`default_nettype wire

// file: bench/dcpd_sva.sv
`timescale 1ns/10ps
`default_nettype none
module dcpd_sva (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic out_ready,
  input wire logic out_valid,
  input wire logic [7:0] red_code,
  input wire logic [7:0] green_code,
  input wire logic [7:0] blue_code,
  input wire logic [8:0] red_level,
  input wire logic [8:0] green_level,
  input wire logic [8:0] blue_level,
  input wire logic pll_bypass
);
  logic [31:0] ctrl_r;
  logic [31:0] ctrl_nxt;
  logic [8:0] rd;
  logic [8:0] gd;
  logic [8:0] bd;
  // The control word is shadowed from the bus, since it is not a port.
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (reg_wr && reg_addr == dcpd_pkg::CTRL_OFFSET) begin
      ctrl_nxt = reg_wdata;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= 32'h0;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end
  assign rd = red_level - {1'b0, red_code};
  assign gd = green_level - {1'b0, green_code};
  assign bd = blue_level - {1'b0, blue_code};
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_pedestal_sum: assert property (
    out_valid |-> rd inside {9'h000, 9'h014, 9'h06C, 9'h080})
    else $error("level minus code is no pedestal sum");
  a_sync_all: assert property (out_valid |-> rd == gd && gd == bd)
    else $error("channels carry different pedestals");
  a_black_off: assert property (
    out_valid && !ctrl_r[12] |-> !(rd inside {9'h014, 9'h080}))
    else $error("black pedestal while disabled");
  a_sync_off: assert property (
    out_valid && !ctrl_r[5] |-> rd <= 9'h014)
    else $error("sync pedestal while disabled");
  a_black_on: assert property (
    out_valid && ctrl_r[12] && red_code != 8'h00
    |-> rd inside {9'h014, 9'h080})
    else $error("black pedestal missing in active display");
  a_bypass_on: assert property (
    $past(ctrl_r[0]) |-> pll_bypass)
    else $error("multiplier not bypassed in direct mode");
  a_bypass_off: assert property (
    !$past(ctrl_r[0]) && $past(ctrl_r[1]) |-> !pll_bypass)
    else $error("multiplier bypassed while selected");
  a_out_hold: assert property (
    out_valid && !out_ready
    |=> out_valid && $stable(red_level) && $stable(blue_code))
    else $error("output word changed while stalled");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
endmodule
bind dcpd_top dcpd_sva i_dcpd_sva (.clk(clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .out_ready(out_ready),
  .out_valid(out_valid), .red_code(red_code), .green_code(green_code),
  .blue_code(blue_code), .red_level(red_level),
  .green_level(green_level), .blue_level(blue_level),
  .pll_bypass(pll_bypass));
`default_nettype wire

// file: bench/dcpd_fstore.sv
`timescale 1ns/10ps
`default_nettype none
module dcpd_fstore (
  input wire logic start,
  input wire dcpd_pkg::dcpd_word_t word,
  output logic pix_clk,
  output var dcpd_pkg::dcpd_word_t lanes
);
  initial begin
    pix_clk = 1'b0;
    lanes = '0;
  end
  // The dot clock stands still between pixels; after the hold window
  // the lanes turn to the inverse so a late sample cannot look right.
  always @(posedge start) begin
    lanes = word;
    #103 pix_clk = 1'b1;
    #90 lanes = ~word;
    #10 pix_clk = 1'b0;
  end
endmodule
`default_nettype wire

// file: bench/dcpd_top_test.sv
`timescale 1ns/10ps
`default_nettype none
module dcpd_top_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic out_ready = 1'b0;
  logic start = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic out_valid;
  logic pll_bypass;
  logic pix_clk;
  wire dcpd_pkg::dcpd_level_t lvl;
  wire dcpd_pkg::dcpd_pixel_t code;
  dcpd_pkg::dcpd_word_t word = '0;
  dcpd_pkg::dcpd_word_t lanes;
  int err_count = 0;
  int checks_done = 0;
  always #12.5 clk = ~clk;
  dcpd_fstore i_dcpd_fstore (.start(start), .word(word),
    .pix_clk(pix_clk), .lanes(lanes));
  dcpd_top i_dcpd_top (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pix_clk(pix_clk),
    .red_pixel_lane(lanes.pix.red_pixel_lane),
    .green_pixel_lane(lanes.pix.green_pixel_lane),
    .blue_pixel_lane(lanes.pix.blue_pixel_lane),
    .pix_blank(lanes.blank), .pix_sync(lanes.sync),
    .out_ready(out_ready), .out_valid(out_valid),
    .red_code(code.red_pixel_lane), .green_code(code.green_pixel_lane),
    .blue_code(code.blue_pixel_lane), .red_level(lvl.red),
    .green_level(lvl.green), .blue_level(lvl.blue),
    .pll_bypass(pll_bypass));
  task automatic end_sim;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rc(string what, logic [3:0] a, logic [31:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 cmp(what, exp, reg_rdata);
    @(posedge clk);
  endtask
  task automatic snd(logic b, logic s, logic [23:0] p);
    word <= {b, s, p};
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    repeat (9) @(posedge clk);
  endtask
  // Outputs are held stalled until judged, so each word is seen whole.
  task automatic chk(logic b, logic s, logic [23:0] p, logic [31:0] ctl);
    int n;
    logic [7:0] c;
    logic [8:0] base;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (out_valid === 1'b1) break;
    end
    if (n == 40) begin
      cmp("out_valid", 32'h1, 32'(out_valid));
      end_sim();
    end
    base = ctl[12] && !b ? 9'h014 : 9'h000;
    base = base + (ctl[5] && !s ? 9'h06C : 9'h000);
    for (int i = 0; i < 3; i++) begin
      c = b ? 8'h00 : p[8*i +: 8];
      cmp("code", 32'(c), 32'(code[8*i +: 8]));
      cmp("level", 32'(base) + 32'(c), 32'(lvl[9*i +: 9]));
    end
    out_ready <= 1'b1;
    @(posedge clk);
    out_ready <= 1'b0;
  endtask
  task automatic px(logic b, logic s, logic [23:0] p, logic [31:0] ctl);
    snd(b, s, p);
    chk(b, s, p, ctl);
  endtask
  task automatic reg_test;
    rc("ctrl", 4'h0, 32'h0);
    rc("mask", 4'h8, 32'hFF);
    rc("unmapped", 4'hC, 32'h0);
    wr(4'h8, 32'h0);
    wr(4'h0, 32'h1021);
    rc("ctrl", 4'h0, 32'h1021);
    cmp("bypass", 32'h1, 32'(pll_bypass));
    $display("register test done");
  endtask
  task automatic level_test;
    logic [31:0] ctl [4] = '{32'h1, 32'h21, 32'h1001, 32'h1021};
    for (int k = 0; k < 4; k++) begin
      wr(4'h0, ctl[k]);
      px(1'b0, 1'b0, 24'hFF005A, ctl[k]);
      px(1'b1, 1'b0, 24'h123456, ctl[k]);
      px(1'b1, 1'b1, 24'h654321, ctl[k]);
    end
    $display("level test done");
  endtask
  task automatic stall_test;
    for (int i = 0; i < 4; i++) snd(1'b0, 1'b0, 24'h80FF01 + 24'(i));
    rc("drops", 4'h4, 32'h1);
    for (int i = 0; i < 3; i++) begin
      chk(1'b0, 1'b0, 24'h80FF01 + 24'(i), 32'h1021);
    end
    $display("stall test done");
  endtask
  // Multiplexed mode: the mask applies and the multiplier may be used.
  task automatic mode_test;
    wr(4'h8, 32'h0000000F);
    wr(4'h0, 32'h2);
    @(posedge clk);
    cmp("bypass", 32'h0, 32'(pll_bypass));
    snd(1'b0, 1'b0, 24'hFF005A);
    chk(1'b0, 1'b0, 24'h0F000A, 32'h2);
    wr(4'h0, 32'h0);
    @(posedge clk);
    cmp("bypass", 32'h1, 32'(pll_bypass));
    $display("mode test done");
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    reg_test();
    level_test();
    stall_test();
    mode_test();
    end_sim();
  end
endmodule
`default_nettype wire
